/* dv/display_chain_model.sv */
// five stacked 3-digit shift-register display modules, behavioural
// assumes the driver's shift clock, data and latch lines
`timescale 1ns/1ps
module display_chain_model (
    // serial link
    input  wire logic         shift_clock_out,
    input  wire logic         shift_data_out,
    input  wire logic         latch_enable_out,
    // chain end and latched segments, low lights a segment
    output logic              chain_output,
    output logic      [119:0] shown
);
    logic [119:0] chain_q;
    always_ff @(posedge shift_clock_out) chain_q <= {chain_q[118:0], shift_data_out};
    always_ff @(posedge latch_enable_out) shown <= chain_q;
    assign chain_output = chain_q[119];
endmodule

/* dv/seven_segment_serial_driver_chk.sv */
// port-level assertions on the serial seven-segment frame driver
// assumes one pclk domain and presetn active low, bound below
`timescale 1ns/1ps
module seven_segment_serial_driver_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // display chain
    input wire logic        shift_clock_out,
    input wire logic        shift_data_out,
    input wire logic        latch_enable_out,
    // frame status
    input wire logic        frame_start_flag,
    input wire logic        frame_done_level,
    input wire logic        frame_done_pulse,
    input wire logic [31:0] timing_counter_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // allow one cycle of skew between counter and flags
    sequence near_zero_s;
        (timing_counter_out[15:0] + 16'h0001) <= 16'h0002;
    endsequence
    sequence shift_rise_s;
        $rose(shift_clock_out);
    endsequence
    AST_SCLK: assert property (shift_clock_out == timing_counter_out[8])
        else $error("shift clock differs from counter bit 8");
    AST_CNT: assert property ((timing_counter_out != 0) |=>
        timing_counter_out == $past(timing_counter_out) + 32'h0000_0001)
        else $error("counter did not step by one");
    AST_PULSE: assert property (frame_done_pulse |=> !frame_done_pulse)
        else $error("done pulse longer than one cycle");
    AST_DONE: assert property (frame_done_pulse |=> frame_done_level)
        else $error("done level missing after done pulse");
    AST_LATCH: assert property ($rose(latch_enable_out) |-> near_zero_s)
        else $error("latch rose away from rollover");
    AST_START: assert property ($rose(frame_start_flag) |-> near_zero_s)
        else $error("frame start away from low half zero");
    AST_FLAG: assert property ($fell(frame_start_flag) |-> timing_counter_out[15:12] == 4'hF)
        else $error("frame flag fell too early");
    AST_DATA: assert property (shift_rise_s |-> $stable(shift_data_out))
        else $error("data moved at shift clock rise");
endmodule

bind digit_bit_serialiser seven_segment_serial_driver_chk i_chk (.pclk, .presetn,
    .shift_clock_out, .shift_data_out, .latch_enable_out, .frame_start_flag,
    .frame_done_level, .frame_done_pulse, .timing_counter_out);

/* dv/seven_segment_serial_driver_tb.sv */
// self-checking bench: apb set-up, one single-request frame, chain readback
// assumes the register map of seg_drv_consts.svh; run is about two frames long
`timescale 1ns/1ps
`include "seg_drv_consts.svh"
module seven_segment_serial_driver_tb;
    localparam logic [111:0] HEX = {7'h71, 7'h79, 7'h5E, 7'h39, 7'h7C, 7'h77, 7'h6F, 7'h7F,
                                    7'h07, 7'h7D, 7'h6D, 7'h66, 7'h4F, 7'h5B, 7'h06, 7'h3F};
    logic         pclk = 1'b0;
    logic         presetn = 1'b0;
    logic         psel = 1'b0;
    logic         penable = 1'b0;
    logic         pwrite = 1'b0;
    logic [11:0]  paddr = 12'h000;
    logic [31:0]  pwdata = 32'h0000_0000;
    logic [31:0]  prdata, timing_counter_out, rd;
    logic         pready, pslverr, err, shift_clock_out, shift_data_out, latch_enable_out;
    logic         frame_start_flag, frame_done_level, frame_done_pulse;
    logic [119:0] shown;
    logic [8:0]   w [15];
    int           fail_count = 0, n_checks = 0, seed = 32'h7e0c72d1, i;

    digit_bit_serialiser i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .shift_clock_out, .shift_data_out, .latch_enable_out,
        .frame_start_flag, .frame_done_level, .frame_done_pulse, .timing_counter_out);
    display_chain_model i_chain (.shift_clock_out, .shift_data_out, .latch_enable_out,
        .chain_output(), .shown);

    function automatic logic [7:0] seg_exp(input logic [8:0] d);
        return d[8] ? ~{d[7], HEX[7*d[3:0] +: 7]} : d[7:0];
    endfunction
    task automatic results();
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bound(input int c, input int lim);
        if (c >= lim) begin
            fail_count++;
            $display("Error %0t: wait ran out", $time);
            results();
        end
    endtask
    // sel 0: done pulse high, sel 1: latch low
    task automatic wait_sig(input int sel, input int lim);
        int c;
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (!(sel == 0 ? frame_done_pulse === 1'b1 : latch_enable_out === 1'b0)
                   && c < lim);
        bound(c, lim);
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int c;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (pready !== 1'b1 && c < 20);
        bound(c, 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    initial begin
        forever #2 pclk = ~pclk;
    end
    initial begin
        repeat (4) @(posedge pclk);
        chk(timing_counter_out, 0);
        chk({shift_data_out, latch_enable_out, frame_start_flag, frame_done_level,
             frame_done_pulse}, 5'b10000);
        presetn <= 1'b1;
        for (i = 0; i < 15; i++) w[i] = 9'($random(seed));
        w[0] = 9'h18A;
        w[14] = 9'h000;
        apb(1'b0, `OFS_CTRL, 0);
        chk({err, rd}, 33'h0_0000_00F0);
        apb(1'b1, 12'h100, 32'h0000_0001);
        chk(err, 1);
        apb(1'b0, 12'h100, 0);
        chk({err, rd}, 33'h1_0000_0000);
        for (i = 0; i < 15; i++) apb(1'b1, `OFS_DIGIT_BASE + 12'(4 * i), {23'h0, w[i]});
        apb(1'b0, `OFS_DIGIT_BASE + 12'h014, 0);
        chk({err, rd}, {24'h0, w[5]});
        apb(1'b1, `OFS_CTRL, 32'h0000_00F2);
        wait_sig(0, 140000);
        chk({frame_start_flag, frame_done_level}, 2'b01);
        wait_sig(1, 300);
        for (i = 0; i < 15; i++) chk(shown[8*i +: 8], seg_exp(w[i]));
        apb(1'b0, `OFS_STATUS, 0);
        chk({err, rd}, 33'h0_0000_0002);
        apb(1'b1, `OFS_CTRL, 32'h0000_00E1);
        apb(1'b0, `OFS_CTRL, 0);
        chk({err, rd}, 33'h0_0000_00E1);
        results();
    end
endmodule

/* hw/digit_bit_serialiser.sv */
// serial seven-segment frame driver with an apb register file
// assumes an apb master on pclk and a chain of up to five 3-digit shift-register modules
//
// Contract
// [R1] state clears asynchronously while presetn is low; brightness resets to 4'hF and shift data to 1
// [R2] fifteen 9-bit digit words, index 3*module+position, position 0 is right
// [R3] continuous request level sends frames back to back with pwm brightness
// [R4] a single request sends a fixed number of frames at full brightness
// [R5] frame start flag rises at frame start, stays high nearly whole frame
// [R6] frame end gives a held done level and a one-cycle done pulse
// [R7] 4-bit brightness sets intensity, used only in continuous mode
// [R8] 32-bit free running counter, all bits out, low 16 time frames
// [R9] frame is 16 slots, 128 shift clocks, then one latch pulse
// [R10] frame begins when the low 16 counter bits are all zero
// [R11] frames stop only when request low and repeat counter is zero
// [R12] shift clock is counter bit 8
// [R13] bit in packet selected by counter bits 11 to 9, 16 packets
// [R14] digit slot selected by counter bits 15 to 12
// [R15] latch goes high when the low counter half rolls over to zero
// [R16] single mode: latch low again at the next rising shift clock
// [R17] continuous mode: latch low at a point set by brightness
// [R18] bit 8 clear sends bits 7 to 0 raw, low lights segment
// [R19] bit 8 set decodes hex in bits 3 to 0, bit 7 is point
// [R20] software keeps digit words stable until the frame ends
// [R21] a single update pulse starts one frame from present words
// [R22] latch rising edge loads displays, low lights, high blanks
// [R23] modules shift on rising shift clock and pass data down the chain
// [R24] common anode: decoded patterns are sent inverted
// [R25] word 0 lands in first module right digit, spare slot blank
// [R26] packets go msb first; repeat count reloads on each request
//
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "seg_drv_consts.svh"

module digit_bit_serialiser (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // display chain
    output logic             shift_clock_out,
    output logic             shift_data_out,
    output logic             latch_enable_out,
    // frame status
    output logic             frame_start_flag,
    output logic             frame_done_level,
    output logic             frame_done_pulse,
    output logic      [31:0] timing_counter_out
);

    // segments active high, bit 0 = a ... bit 6 = g
    function automatic logic [6:0] hex_segments(input logic [3:0] v);
        logic [6:0] s;
        s = 7'h00;
        unique case (v)
            4'h0: s = 7'h3F;
            4'h1: s = 7'h06;
            4'h2: s = 7'h5B;
            4'h3: s = 7'h4F;
            4'h4: s = 7'h66;
            4'h5: s = 7'h6D;
            4'h6: s = 7'h7D;
            4'h7: s = 7'h07;
            4'h8: s = 7'h7F;
            4'h9: s = 7'h6F;
            4'hA: s = 7'h77;
            4'hB: s = 7'h7C;
            4'hC: s = 7'h39;
            4'hD: s = 7'h5E;
            4'hE: s = 7'h79;
            4'hF: s = 7'h71;
        endcase
        return s;
    endfunction

    // wire pattern of one digit word, low lights a segment
    function automatic logic [7:0] wire_pattern(input logic [8:0] w);
        logic [7:0] p;
        p = w[7:0];                                          // [R18]
        if (w[8]) begin
            p = ~{w[7], hex_segments(w[3:0])};               // [R19] [R24]
        end
        return p;
    endfunction

    // true for addresses inside the digit word window
    function automatic logic is_digit_addr(input logic [11:0] a);
        return a >= `OFS_DIGIT_BASE && a <= `OFS_DIGIT_LAST && a[1:0] == 2'b00;
    endfunction

    seg_drv_pkg::state_t s_q;
    seg_drv_pkg::state_t s_d;
    seg_drv_pkg::apb_req_t req;

    assign req = '{psel: psel, penable: penable, pwrite: pwrite,
                   paddr: paddr, pwdata: pwdata};

    always_comb begin
        logic        access;
        logic        wr_take;
        logic        once_req;
        logic [15:0] lo;
        logic [3:0]  slot;
        logic [2:0]  bitn;
        logic [7:0]  pkt;
        logic [3:0]  widx;
        logic        start;
        logic [31:0] rd;
        logic        bad;

        s_d      = s_q;
        access   = req.psel && req.penable;
        wr_take  = access && s_q.rsp.pready && req.pwrite;
        once_req = 1'b0;
        widx     = 4'(req.paddr[5:2] - 4'h0);
        rd       = 32'h0000_0000;
        bad      = 1'b0;
        lo       = 16'h0000;
        slot     = 4'h0;
        bitn     = 3'h0;
        pkt      = `BLANK_SEG;
        start    = 1'b0;

        // apb: one wait state, answer registered
        s_d.rsp.pready  = access && !s_q.rsp.pready;
        if (access && !s_q.rsp.pready) begin
            unique case (req.paddr)
                `OFS_CTRL: begin
                    rd[`CTRL_CONT_BIT]               = s_q.refresh_request;
                    rd[`CTRL_PWM_MSB:`CTRL_PWM_LSB]  = s_q.brightness_level;
                end
                `OFS_STATUS: begin
                    rd[`STAT_FRAME_BIT] = s_q.flags.frame_start_flag;
                    rd[`STAT_DONE_BIT]  = s_q.flags.frame_done_level;
                    rd[`STAT_BUSY_BIT]  = s_q.active;
                    rd[`STAT_CONT_BIT]  = s_q.cont_frame;
                end
                `OFS_COUNTER: rd = s_q.cnt;
                default: begin
                    if (is_digit_addr(req.paddr)) begin
                        rd[8:0] = s_q.digit_words[widx - 4'h0];
                    end else begin
                        bad = 1'b1;
                    end
                end
            endcase
            s_d.rsp.prdata  = rd;
            s_d.rsp.pslverr = bad;
        end

        if (wr_take) begin
            if (req.paddr == `OFS_CTRL) begin
                s_d.refresh_request  = req.pwdata[`CTRL_CONT_BIT];
                s_d.brightness_level = req.pwdata[`CTRL_PWM_MSB:`CTRL_PWM_LSB];
                once_req             = req.pwdata[`CTRL_ONCE_BIT];  // [R21]
            end else if (is_digit_addr(req.paddr)) begin
                s_d.digit_words[widx] = req.pwdata[8:0];             // [R2]
            end
        end

        // free-running timebase
        s_d.cnt = s_q.cnt + 32'h0000_0001;                           // [R8]
        lo      = s_d.cnt[15:0];

        s_d.flags.frame_done_pulse = 1'b0;
        start = 1'b0;
        if (s_q.cnt[15:0] == `LOW_LAST) begin                        // [R10]
            if (s_q.active) begin
                s_d.link.latch_enable_out  = 1'b1;                   // [R15] [R22]
                s_d.flags.frame_done_pulse = 1'b1;                   // [R6]
                s_d.flags.frame_done_level = 1'b1;
            end
            // a request that is still set starts the next frame
            if (s_q.refresh_request || s_q.frame_repeat_count != 4'h0) begin   // [R11]
                start          = 1'b1;
                s_d.cont_frame = s_q.refresh_request;                // [R3]
                if (!s_q.refresh_request) begin
                    s_d.frame_repeat_count = s_q.frame_repeat_count - 4'h1;
                end
            end
            s_d.active = start;
        end
        // reload wins over the decrement in the same cycle
        if (once_req) begin
            s_d.frame_repeat_count = `FRAME_REPEAT_COUNT;            // [R4] [R26]
        end

        if (s_d.active && lo == `FIRST_RISE) begin
            s_d.flags.frame_done_level = 1'b0;
        end
        s_d.flags.frame_start_flag = s_d.active && lo < `FLAG_END;   // [R5]

        // latch back low: first rising shift clock, or brightness point
        if (s_q.link.latch_enable_out && lo[8]) begin
            if (!s_q.cont_frame) begin
                s_d.link.latch_enable_out = 1'b0;                    // [R16]
            end else if (lo[15:12] >= 4'hF - s_q.brightness_level) begin
                s_d.link.latch_enable_out = 1'b0;                    // [R17] [R7]
            end
        end

        // serial stream: slot 0 is the spare that falls off the chain end
        s_d.link.shift_clock_out = lo[8];                            // [R12] [R23]
        slot = lo[15:12];                                            // [R14]
        bitn = lo[11:9];                                             // [R13]
        pkt  = `BLANK_SEG;
        if (slot != 4'h0) begin
            pkt = wire_pattern(s_q.digit_words[4'(4'hF - slot)]);    // [R25] [R20]
        end
        s_d.link.shift_data_out = s_d.active ? pkt[3'h7 - bitn] : 1'b1;   // [R9] [R26]
    end

    // reset values are constants only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin                                          // [R1]
            s_q                    <= '0;
            s_q.brightness_level   <= `PWM_RESET;
            s_q.frame_repeat_count <= `REPEAT_RESET;
            s_q.link.shift_data_out <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata             = s_q.rsp.prdata;
    assign pready             = s_q.rsp.pready;
    assign pslverr            = s_q.rsp.pslverr;
    assign shift_clock_out    = s_q.link.shift_clock_out;
    assign shift_data_out     = s_q.link.shift_data_out;
    assign latch_enable_out   = s_q.link.latch_enable_out;
    assign frame_start_flag   = s_q.flags.frame_start_flag;
    assign frame_done_level   = s_q.flags.frame_done_level;
    assign frame_done_pulse   = s_q.flags.frame_done_pulse;
    assign timing_counter_out = s_q.cnt;

endmodule

/* hw/seg_drv_consts.svh */
// constants of the serial seven-segment frame driver
// assumes byte addressing on a 32-bit apb bus
`ifndef SEG_DRV_CONSTS_SVH
`define SEG_DRV_CONSTS_SVH

// register byte offsets
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_COUNTER     12'h008
`define OFS_DIGIT_BASE  12'h040
`define OFS_DIGIT_LAST  12'h078

// control register fields
`define CTRL_CONT_BIT   0
`define CTRL_ONCE_BIT   1
`define CTRL_PWM_LSB    4
`define CTRL_PWM_MSB    7

// status register fields
`define STAT_FRAME_BIT  0
`define STAT_DONE_BIT   1
`define STAT_BUSY_BIT   2
`define STAT_CONT_BIT   3

// reset values
`define PWM_RESET       4'hF
`define REPEAT_RESET    4'h0

// frames sent per single update request
`define FRAME_REPEAT_COUNT 4'h1

// frame timing on the low counter half, blank slot pattern and digit count
`define LOW_LAST        16'hFFFF
`define FIRST_RISE      16'h0100
`define FLAG_END        16'hFF00
`define BLANK_SEG       8'hFF
`define DIGIT_COUNT     15

`endif

/* hw/seg_drv_pkg.sv */
// types of the serial seven-segment frame driver
// constants live in seg_drv_consts.svh
package seg_drv_pkg;

    typedef logic [14:0][8:0] digit_array_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic shift_clock_out;
        logic shift_data_out;
        logic latch_enable_out;
    } link_t;

    typedef struct packed {
        logic frame_start_flag;
        logic frame_done_level;
        logic frame_done_pulse;
    } flags_t;

    typedef struct packed {
        digit_array_t digit_words;
        logic         refresh_request;
        logic [3:0]   brightness_level;
        logic [3:0]   frame_repeat_count;
        logic [31:0]  cnt;
        logic         active;
        logic         cont_frame;
        link_t        link;
        flags_t       flags;
        apb_rsp_t     rsp;
    } state_t;

endpackage
